// ==== inc/rsf_pkg.sv ====
// constants shared by the request source filter block
package rsf_pkg;

  // register bus widths
  localparam int RSF_ADDR_W = 12;
  localparam int RSF_DATA_W = 32;

  // filter set and clear offsets
  localparam logic [11:0] RSF_OFS_ASYNC_HIGH_SET = 12'h100;
  localparam logic [11:0] RSF_OFS_ASYNC_HIGH_CLEAR = 12'h104;
  localparam logic [11:0] RSF_OFS_ASYNC_LOW_SET = 12'h108;
  localparam logic [11:0] RSF_OFS_ASYNC_LOW_CLEAR = 12'h10c;
  localparam logic [11:0] RSF_OFS_PHYS_HIGH_SET = 12'h110;
  localparam logic [11:0] RSF_OFS_PHYS_HIGH_CLEAR = 12'h114;
  localparam logic [11:0] RSF_OFS_PHYS_LOW_SET = 12'h118;
  localparam logic [11:0] RSF_OFS_PHYS_LOW_CLEAR = 12'h11c;

  // statistics and last decision registers
  localparam logic [11:0] RSF_OFS_STATS = 12'h120;
  localparam logic [11:0] RSF_OFS_LAST = 12'h124;

  // filter indices within the bank
  localparam int RSF_IDX_ASYNC_HIGH = 0;
  localparam int RSF_IDX_ASYNC_LOW = 1;
  localparam int RSF_IDX_PHYS_HIGH = 2;
  localparam int RSF_IDX_PHYS_LOW = 3;
  localparam int RSF_NUM_FILTERS = 4;

  // reset values and counter ceiling
  localparam logic [31:0] RSF_FILTER_RESET = 32'h0000_0000;
  localparam logic [15:0] RSF_COUNT_RESET = 16'h0000;
  localparam logic [15:0] RSF_COUNT_MAX = 16'hffff;
  localparam logic [31:0] RSF_LAST_RESET = 32'h0000_0000;

  // field layout of filters
  localparam int RSF_ALL_BUSES_BIT = 31;
  localparam logic [31:0] RSF_HIGH_NODE_MASK = 32'h7fff_ffff;
  localparam logic [31:0] RSF_LOW_NODE_MASK = 32'hffff_ffff;

  // field layout of a node identifier
  localparam int RSF_BUS_MSB = 15;
  localparam int RSF_BUS_LSB = 6;
  localparam int RSF_NODE_MSB = 5;
  localparam int RSF_NODE_LSB = 0;
  localparam int RSF_NODE_HIGH_BIT = 5;
  localparam logic [4:0] RSF_NODE_NO_HIGH_BIT = 5'h1f;

  // bus number that always means the local bus
  localparam logic [9:0] RSF_BUS_LOCAL_ALIAS = 10'h3ff;

endpackage : rsf_pkg

// ==== design/rsf_lookup.sv ====
// per-source-node decision logic of the request source filter
`timescale 1ns/1ps
`default_nettype none

module rsf_lookup
  import rsf_pkg::*;
(
  // filter contents
  input wire logic [31:0] async_high,
  input wire logic [31:0] async_low,
  input wire logic [31:0] phys_high,
  input wire logic [31:0] phys_low,
  // request
  input wire logic [15:0] src_id,
  input wire logic [9:0] local_bus_id,
  input wire logic bound_phys,
  // decision
  output logic accept,
  output logic to_phys,
  output logic to_async_request_receive_queue
);

  // node 63 maps onto the all-buses bit, so it never has an enable
  function automatic logic rsf_node_bit(input logic [31:0] high, input logic [31:0] low,
                                        input logic [5:0] node);
    logic [4:0] pos;
    pos = node[4:0];
    if (node[RSF_NODE_HIGH_BIT]) begin
      rsf_node_bit = (pos == RSF_NODE_NO_HIGH_BIT) ? 1'b0 : high[pos];
    end else begin
      rsf_node_bit = low[pos];
    end
  endfunction : rsf_node_bit

  wire logic [9:0] src_bus = src_id[RSF_BUS_MSB:RSF_BUS_LSB];
  wire logic [5:0] src_node = src_id[RSF_NODE_MSB:RSF_NODE_LSB];
  wire logic is_local = (src_bus == local_bus_id) || (src_bus == RSF_BUS_LOCAL_ALIAS);
  wire logic async_node_enable = rsf_node_bit(async_high, async_low, src_node);
  wire logic phys_node_enable = rsf_node_bit(phys_high, phys_low, src_node);
  wire logic async_accept_all_buses = async_high[RSF_ALL_BUSES_BIT];
  wire logic phys_accept_all_buses = phys_high[RSF_ALL_BUSES_BIT];

  // node bits count only for local sources
  wire logic async_ok = is_local ? async_node_enable : async_accept_all_buses;
  wire logic phys_ok = is_local ? phys_node_enable : phys_accept_all_buses;

  assign accept = async_ok;
  assign to_phys = async_ok && bound_phys && phys_ok;
  assign to_async_request_receive_queue = async_ok && !(bound_phys && phys_ok);

endmodule : rsf_lookup

`default_nettype wire

// ==== design/rsf_top.sv ====
// register bank and request decision stage of the request source filter
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - requests from a source whose enable bit is clear get no ack and no queueing
// - per-node comparison applies only to sources on the local bus
// - remote sources accepted only when async all-buses bit 31 is set
// - async high bits 30:0 enable local nodes numbered bit plus 32
// - async low bits 31:0 enable local nodes 0 to 31
// - physical-bound request with clear physical bit goes to the request queue
// - physical high bit 31 accepts physical requests from all remote buses
// - physical high bits 30:0 route local node bit plus 32 physically
// - physical low bits 31:0 route local node equal to bit physically
// - set and clear writes ignored while the bus reset event flag is high
// - bus reset clears every per-node enable bit in all filters
// - bus reset leaves both all-buses bits unchanged
// - each filter has set and clear addresses 4 apart, 0x100 to 0x11c
// - node id is bus number 15:6 and node number 5:0
module rsf_top
  import rsf_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // bus reset status from the link
  input wire logic bus_reset_event_flag,
  input wire logic bus_reset_pulse,
  // own bus number
  input wire logic [9:0] local_bus_id,
  // incoming request
  input wire logic req_valid,
  input wire logic [15:0] req_src_id,
  input wire logic req_bound_phys,
  // decision
  output logic resp_valid,
  output logic resp_ack,
  output logic resp_phys,
  output logic resp_async_request_receive_queue,
  output logic [15:0] resp_src_id
);

  // address decode helpers, shared by read and write paths
  function automatic logic rsf_filter_hit(input logic [11:0] addr);
    rsf_filter_hit = (addr >= RSF_OFS_ASYNC_HIGH_SET) && (addr <= RSF_OFS_PHYS_LOW_CLEAR)
                     && (addr[1:0] == 2'h0);
  endfunction : rsf_filter_hit

  function automatic logic [1:0] rsf_filter_index(input logic [11:0] addr);
    logic [11:0] rel;
    rel = addr - RSF_OFS_ASYNC_HIGH_SET;
    rsf_filter_index = rel[4:3];
  endfunction : rsf_filter_index

  // filter storage
  logic [31:0] filter_q [RSF_NUM_FILTERS];
  logic [31:0] filter_d [RSF_NUM_FILTERS];

  // statistics and last decision
  logic [15:0] reject_count_q;
  logic [15:0] reject_count_d;
  logic [15:0] redirect_count_q;
  logic [15:0] redirect_count_d;
  logic [31:0] last_q;
  logic [31:0] last_d;

  // output registers
  logic [31:0] reg_rdata_q;
  logic [31:0] reg_rdata_d;
  logic resp_valid_q;
  logic resp_ack_q;
  logic resp_phys_q;
  logic resp_async_request_receive_queue_q;
  logic [15:0] resp_src_id_q;

  // write decode
  wire logic wr_filter = reg_wr && rsf_filter_hit(reg_addr);
  wire logic [1:0] wr_index = rsf_filter_index(reg_addr);
  wire logic wr_is_clear = reg_addr[2];
  wire logic wr_allowed = wr_filter && !bus_reset_event_flag;
  wire logic wr_stats = reg_wr && (reg_addr == RSF_OFS_STATS);

  // per-filter next value
  genvar gi;
  generate
    for (gi = 0; gi < RSF_NUM_FILTERS; gi++) begin : g_filter
      localparam logic [31:0] NODE_MASK =
        ((gi == RSF_IDX_ASYNC_HIGH) || (gi == RSF_IDX_PHYS_HIGH)) ?
        RSF_HIGH_NODE_MASK : RSF_LOW_NODE_MASK;
      wire logic sel = wr_allowed && (wr_index == 2'(gi));
      wire logic [31:0] set_val = filter_q[gi] | reg_wdata;
      wire logic [31:0] clr_val = filter_q[gi] & ~reg_wdata;
      wire logic [31:0] written = sel ? (wr_is_clear ? clr_val : set_val) : filter_q[gi];
      // bus reset hits node bits only; all-buses bits keep any write
      assign filter_d[gi] = bus_reset_pulse ? (written & ~NODE_MASK) : written;
    end
  endgenerate

  // request decision
  wire logic dec_accept;
  wire logic dec_phys;
  wire logic dec_async_request_receive_queue;

  rsf_lookup u_lookup (
    .async_high(filter_q[RSF_IDX_ASYNC_HIGH]),
    .async_low(filter_q[RSF_IDX_ASYNC_LOW]),
    .phys_high(filter_q[RSF_IDX_PHYS_HIGH]),
    .phys_low(filter_q[RSF_IDX_PHYS_LOW]),
    .src_id(req_src_id),
    .local_bus_id(local_bus_id),
    .bound_phys(req_bound_phys),
    .accept(dec_accept),
    .to_phys(dec_phys),
    .to_async_request_receive_queue(dec_async_request_receive_queue)
  );

  // counters saturate; an event in the clearing cycle still counts once
  wire logic count_reject = req_valid && !dec_accept;
  wire logic count_redirect = req_valid && req_bound_phys && dec_async_request_receive_queue;
  wire logic [15:0] reject_base = wr_stats ? RSF_COUNT_RESET : reject_count_q;
  wire logic [15:0] redirect_base = wr_stats ? RSF_COUNT_RESET : redirect_count_q;

  assign reject_count_d = (count_reject && (reject_base != RSF_COUNT_MAX)) ?
                          reject_base + 16'h0001 : reject_base;
  assign redirect_count_d = (count_redirect && (redirect_base != RSF_COUNT_MAX)) ?
                            redirect_base + 16'h0001 : redirect_base;

  // last decision: {ack, phys, async_request_receive_queue, bound phys, 12'h0, source id}
  assign last_d = req_valid ?
                  {dec_accept, dec_phys, dec_async_request_receive_queue, req_bound_phys, 12'h000, req_src_id} :
                  last_q;

  // read decode; both addresses of a filter show its value
  wire logic rd_filter = rsf_filter_hit(reg_addr);
  wire logic [1:0] rd_index = rsf_filter_index(reg_addr);
  wire logic [31:0] rd_filter_val = filter_q[rd_index];
  wire logic [31:0] rd_mux =
    rd_filter ? rd_filter_val :
    (reg_addr == RSF_OFS_STATS) ? {redirect_count_q, reject_count_q} :
    (reg_addr == RSF_OFS_LAST) ? last_q :
    32'h0000_0000;

  // read data lives for exactly the cycle after the strobe
  assign reg_rdata_d = reg_rd ? rd_mux : 32'h0000_0000;

  // filters
  always_ff @(posedge clk) begin
    for (int i = 0; i < RSF_NUM_FILTERS; i++) begin
      filter_q[i] <= reset ? RSF_FILTER_RESET : filter_d[i];
    end
  end

  // statistics
  always_ff @(posedge clk) begin
    if (reset) begin
      reject_count_q <= RSF_COUNT_RESET;
      redirect_count_q <= RSF_COUNT_RESET;
      last_q <= RSF_LAST_RESET;
    end else begin
      reject_count_q <= reject_count_d;
      redirect_count_q <= redirect_count_d;
      last_q <= last_d;
    end
  end

  // register read port
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= 32'h0000_0000;
    end else begin
      reg_rdata_q <= reg_rdata_d;
    end
  end

  // decision outputs, one cycle after the request
  always_ff @(posedge clk) begin
    if (reset) begin
      resp_valid_q <= 1'b0;
      resp_ack_q <= 1'b0;
      resp_phys_q <= 1'b0;
      resp_async_request_receive_queue_q <= 1'b0;
      resp_src_id_q <= 16'h0000;
    end else begin
      resp_valid_q <= req_valid;
      resp_ack_q <= req_valid && dec_accept;
      resp_phys_q <= req_valid && dec_phys;
      resp_async_request_receive_queue_q <= req_valid && dec_async_request_receive_queue;
      resp_src_id_q <= req_valid ? req_src_id : 16'h0000;
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign resp_valid = resp_valid_q;
  assign resp_ack = resp_ack_q;
  assign resp_phys = resp_phys_q;
  assign resp_async_request_receive_queue = resp_async_request_receive_queue_q;
  assign resp_src_id = resp_src_id_q;

endmodule : rsf_top

`default_nettype wire

// ==== verification/rsf_properties.sv ====
// concurrent checks on the request source filter ports
`timescale 1ns/1ps
`default_nettype none
module rsf_properties (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // request and decision
  input wire logic [9:0] local_bus_id,
  input wire logic req_valid,
  input wire logic [15:0] req_src_id,
  input wire logic req_bound_phys,
  input wire logic resp_valid,
  input wire logic resp_ack,
  input wire logic resp_phys,
  input wire logic resp_async_request_receive_queue,
  input wire logic [15:0] resp_src_id
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_req;
    req_valid;
  endsequence
  sequence s_req_queue;
    req_valid && !req_bound_phys;
  endsequence
  // node 63 has no enable bit anywhere
  sequence s_node63;
    req_valid && req_src_id[5:0] == 6'h3f && req_src_id[15:6] == local_bus_id;
  endsequence
  a_resp_latency: assert property (s_req |=> resp_valid)
    else $error("request got no decision");
  a_no_spurious: assert property (!req_valid |=> !resp_valid)
    else $error("decision without request");
  a_src_echo: assert property (s_req |=> resp_src_id == $past(req_src_id))
    else $error("source id not echoed");
  a_route_one: assert property (resp_valid |-> !(resp_phys && resp_async_request_receive_queue))
    else $error("two routes at once");
  a_reject_quiet: assert property (resp_valid && !resp_ack |-> !resp_phys && !resp_async_request_receive_queue)
    else $error("rejected request routed");
  a_ack_routed: assert property (resp_valid && resp_ack |-> resp_phys || resp_async_request_receive_queue)
    else $error("accepted request has no route");
  a_queue_stays: assert property (s_req_queue |=> !resp_phys)
    else $error("queue request sent physical");
  a_node63_drop: assert property (s_node63 |=> !resp_ack)
    else $error("node 63 accepted");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : rsf_properties
`default_nettype wire

// ==== verification/rsf_link_model.sv ====
// link side model issuing requests to judge
`timescale 1ns/1ps
`default_nettype none
module rsf_link_model (
  // clock
  input wire logic clk,
  // request
  output logic req_valid,
  output logic [15:0] req_src_id,
  output logic req_bound_phys
);
  initial begin
    req_valid = 1'b0;
    req_src_id = 16'h0;
    req_bound_phys = 1'b0;
  end
  // released lines show the inverse so stale values never pass
  task automatic send(input logic [15:0] s, input logic p);
    @(posedge clk);
    req_valid <= 1'b1;
    req_src_id <= s;
    req_bound_phys <= p;
    @(posedge clk);
    req_valid <= 1'b0;
    req_src_id <= ~s;
    req_bound_phys <= ~p;
  endtask : send
endmodule : rsf_link_model
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench of the request source filter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsf_pkg::*;
  typedef struct packed {logic [15:0] src; logic phys; logic [2:0] exp;} rsf_row_type;
  logic clk, reset, reg_wr, reg_rd, bus_reset_event_flag, bus_reset_pulse;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [9:0] local_bus_id;
  logic req_valid, req_bound_phys, resp_valid, resp_ack, resp_phys, resp_async_request_receive_queue;
  logic [15:0] req_src_id, resp_src_id;
  int n_fail, check_count, cycles;
  // local bus 5; rows give ack, phys, queue
  rsf_row_type rows [9] = '{'{16'h0140, 1'b1, 3'b110}, '{16'h0140, 1'b0, 3'b101},
    '{16'h0145, 1'b1, 3'b101}, '{16'h0141, 1'b1, 3'b000}, '{16'h0160, 1'b1, 3'b110},
    '{16'h0161, 1'b0, 3'b000}, '{16'h017f, 1'b1, 3'b000}, '{16'hffc5, 1'b0, 3'b101},
    '{16'h01c5, 1'b1, 3'b000}};
  rsf_top i_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_reset_event_flag, .bus_reset_pulse, .local_bus_id, .req_valid, .req_src_id,
    .req_bound_phys, .resp_valid, .resp_ack, .resp_phys, .resp_async_request_receive_queue, .resp_src_id);
  rsf_link_model i_link (.clk, .req_valid, .req_src_id, .req_bound_phys);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd
  task automatic req(input logic [15:0] s, input logic p, input logic [2:0] e);
    i_link.send(s, p);
    #1 check({28'h0, resp_valid, resp_ack, resp_phys, resp_async_request_receive_queue}, {28'h0, 1'b1, e});
    check({16'h0, resp_src_id}, {16'h0, s});
  endtask : req
  task automatic stop_test;
    $display("errors %0d checks %0d", n_fail, check_count);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  // ceiling well above the roughly 100 cycles used
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    {reset, reg_wr, reg_rd, bus_reset_event_flag, bus_reset_pulse} = 5'h10;
    reg_addr = 12'h0;
    reg_wdata = 32'h0;
    local_bus_id = 10'h005;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(12'h100 + 12'(4 * i), 32'h0);
    wr(RSF_OFS_ASYNC_LOW_SET, 32'h0000_0023);
    wr(RSF_OFS_ASYNC_LOW_CLEAR, 32'h0000_0002);
    rd(RSF_OFS_ASYNC_LOW_CLEAR, 32'h0000_0021);
    wr(RSF_OFS_ASYNC_HIGH_SET, 32'h1);
    wr(RSF_OFS_PHYS_LOW_SET, 32'h1);
    wr(RSF_OFS_PHYS_HIGH_SET, 32'h1);
    rd(RSF_OFS_PHYS_HIGH_SET, 32'h1);
    wr(12'h200, 32'hffff_ffff);
    rd(12'h200, 32'h0);
    for (int i = 0; i < 9; i++) req(rows[i].src, rows[i].phys, rows[i].exp);
    wr(RSF_OFS_ASYNC_HIGH_SET, 32'h8000_0000);
    req(16'h01c1, 1'b1, 3'b101);
    wr(RSF_OFS_PHYS_HIGH_SET, 32'h8000_0000);
    req(16'h01c1, 1'b1, 3'b110);
    // flag moves on an edge, a cycle ahead of the writes it blocks
    @(posedge clk);
    bus_reset_event_flag <= 1'b1;
    wr(RSF_OFS_PHYS_LOW_SET, 32'hffff_ffff);
    wr(RSF_OFS_PHYS_LOW_CLEAR, 32'h1);
    bus_reset_event_flag <= 1'b0;
    rd(RSF_OFS_PHYS_LOW_SET, 32'h1);
    @(posedge clk);
    bus_reset_pulse <= 1'b1;
    @(posedge clk);
    bus_reset_pulse <= 1'b0;
    rd(RSF_OFS_ASYNC_HIGH_SET, 32'h8000_0000);
    rd(RSF_OFS_ASYNC_LOW_SET, 32'h0);
    rd(RSF_OFS_PHYS_HIGH_CLEAR, 32'h8000_0000);
    rd(RSF_OFS_PHYS_LOW_CLEAR, 32'h0);
    req(16'h0140, 1'b1, 3'b000);
    req(16'h01c5, 1'b1, 3'b110);
    // so far 5 rejects and 2 physical requests sent to the queue
    rd(RSF_OFS_STATS, 32'h0002_0005);
    rd(RSF_OFS_LAST, 32'hd000_01c5);
    wr(RSF_OFS_STATS, 32'h0);
    rd(RSF_OFS_STATS, 32'h0);
    // second reset in mid-run; all-buses bits must fall as well
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 check(reg_rdata, 32'h0);
    check({28'h0, resp_valid, resp_ack, resp_phys, resp_async_request_receive_queue}, 32'h0);
    rd(RSF_OFS_ASYNC_HIGH_SET, 32'h0);
    rd(RSF_OFS_PHYS_HIGH_CLEAR, 32'h0);
    rd(RSF_OFS_LAST, 32'h0);
    req(16'h01c5, 1'b1, 3'b000);
    stop_test;
  end
endmodule : tb
bind rsf_top rsf_properties i_props (.clk, .reset, .reg_rd, .reg_rdata, .local_bus_id,
  .req_valid, .req_src_id, .req_bound_phys, .resp_valid, .resp_ack, .resp_phys, .resp_async_request_receive_queue,
  .resp_src_id);
`default_nettype wire
